/* rmsl_board_strap.sv */
// board strapping model: drives mode and flash strap pins
// assumes the bench picks the pattern before each reset
`timescale 1ns/10ps
`default_nettype none
module rmsl_board_strap (
    input wire logic [2:0] strap_req,
    input wire logic flash_req,
    output logic mode_bit2,
    output logic mode_bit1,
    output logic mode_bit0,
    output logic flash_pin
);
    logic [2:0] code;
    // peripheral code is never strapped, fall back to normal wide
    assign code = (strap_req == 3'h6) ? 3'h7 : strap_req;
    // pins held static across reset release
    assign {mode_bit2, mode_bit1, mode_bit0} = code;
    assign flash_pin = flash_req;
endmodule
`default_nettype wire

/* rmsl_dec_if.sv */
// carrier between the strap latch and its mode decoder
// assumes both ends run in the same clock domain
`timescale 1ns/10ps
`default_nettype none
interface rmsl_dec_if;
    logic [2:0] mode;
    logic flash_strap;
    logic flash_vis_dflt;
    logic expanded;
    logic wide;
    logic special;
    logic emulation;
    logic peripheral;

    // decoder side
    modport dec (
        input mode,
        input flash_strap,
        output flash_vis_dflt,
        output expanded,
        output wide,
        output special,
        output emulation,
        output peripheral
    );

    // latch side
    modport user (
        output mode,
        output flash_strap,
        input flash_vis_dflt,
        input expanded,
        input wide,
        input special,
        input emulation,
        input peripheral
    );
endinterface
`default_nettype wire

/* rmsl_mode_decode.sv */
// combinational decoder from mode code to bus configuration
// assumes a synchronised flash strap level from the latch
`timescale 1ns/10ps
`default_nettype none
module rmsl_mode_decode (
    rmsl_dec_if.dec dif
);
    import rmsl_pkg::*;

    // per-mode bus shape and flash visibility default
    always_comb begin
        dif.flash_vis_dflt = 1'h0;
        dif.expanded = 1'h0;
        dif.wide = 1'h0;
        dif.special = 1'h0;
        dif.emulation = 1'h0;
        dif.peripheral = 1'h0;
        case (dif.mode)
            MODE_SPECIAL_SINGLE: begin
                dif.special = 1'h1;
                dif.flash_vis_dflt = 1'h1; // [R06]
            end
            MODE_EMUL_NARROW: begin
                dif.expanded = 1'h1;
                dif.emulation = 1'h1;
                dif.flash_vis_dflt = ~dif.flash_strap; // [R08]
            end
            MODE_SPECIAL_TEST: begin
                dif.special = 1'h1;
                dif.expanded = 1'h1;
                dif.wide = 1'h1;
                dif.flash_vis_dflt = 1'h0; // [R09]
            end
            MODE_EMUL_WIDE: begin
                dif.expanded = 1'h1;
                dif.wide = 1'h1;
                dif.emulation = 1'h1;
                dif.flash_vis_dflt = ~dif.flash_strap; // [R10]
            end
            MODE_NORMAL_SINGLE: begin
                dif.flash_vis_dflt = 1'h1; // [R11]
            end
            MODE_NORMAL_NARROW: begin
                dif.expanded = 1'h1;
                dif.flash_vis_dflt = dif.flash_strap; // [R12]
            end
            MODE_PERIPHERAL: begin
                dif.peripheral = 1'h1;
                dif.flash_vis_dflt = 1'h1;
            end
            MODE_NORMAL_WIDE: begin
                dif.expanded = 1'h1;
                dif.wide = 1'h1;
                dif.flash_vis_dflt = dif.flash_strap; // [R14]
            end
            default: begin
                dif.flash_vis_dflt = 1'h0;
            end
        endcase
    end
endmodule
`default_nettype wire

/* rmsl_pkg.sv */
// constants shared by the mode strap latch and its decoder
// assumes a 32-bit APB register port with 4-byte aligned registers
package rmsl_pkg;

    // apb address width
    localparam int APB_ADDR_W = 12;

    // register byte offsets
    localparam logic [11:0] OFS_MODE_CTRL = 12'h000;
    localparam logic [11:0] OFS_MISC_CTRL = 12'h004;
    localparam logic [11:0] OFS_CFG_STATUS = 12'h008;

    // mode control fields
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 3;

    // misc control fields
    localparam int MISC_FLASH_VIS_BIT = 0;

    // status fields
    localparam int ST_DONE_BIT = 0;
    localparam int ST_DBG_ACTIVE_BIT = 1;
    localparam int ST_EXPANDED_BIT = 2;
    localparam int ST_WIDE_BIT = 3;
    localparam int ST_SPECIAL_BIT = 4;
    localparam int ST_EMULATION_BIT = 5;
    localparam int ST_WR_USED_BIT = 6;
    localparam int ST_STRAP_MODE_LSB = 8;
    localparam int ST_STRAP_FLASH_BIT = 12;

    // reset values
    localparam logic [2:0] RST_MODE = 3'h0;
    localparam logic RST_FLASH_VIS = 1'h0;
    localparam logic [31:0] RST_PRDATA = 32'h0000_0000;

    // mode codes
    localparam logic [2:0] MODE_SPECIAL_SINGLE = 3'h0;
    localparam logic [2:0] MODE_EMUL_NARROW = 3'h1;
    localparam logic [2:0] MODE_SPECIAL_TEST = 3'h2;
    localparam logic [2:0] MODE_EMUL_WIDE = 3'h3;
    localparam logic [2:0] MODE_NORMAL_SINGLE = 3'h4;
    localparam logic [2:0] MODE_NORMAL_NARROW = 3'h5;
    localparam logic [2:0] MODE_PERIPHERAL = 3'h6;
    localparam logic [2:0] MODE_NORMAL_WIDE = 3'h7;

    // mode code bit that marks a normal (non-special) mode
    localparam int MODE_NORMAL_BIT = 2;

    // synchroniser depth for strap pins
    localparam int SYNC_STAGES = 2;

endpackage

/* rmsl_sl_asserts.sv */
// checker on the strap latch ports
// assumes bound to rmsl_strap_latch, straps held after reset release
`timescale 1ns/10ps
`default_nettype none
module rmsl_sl_asserts (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [rmsl_pkg::APB_ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic MODE_SEL_BIT2,
    input wire logic MODE_SEL_BIT1,
    input wire logic MODE_SEL_BIT0,
    input wire logic FLASH_STRAP_PIN,
    input wire logic DEBUG_ACTIVATE_CMD,
    input wire logic [2:0] MODE_CODE,
    input wire logic FLASH_VISIBLE,
    input wire logic EXPANDED_BUS,
    input wire logic WIDE_BUS,
    input wire logic EMULATION_MODE,
    input wire logic PERIPHERAL_MODE,
    input wire logic DEBUG_ACTIVE,
    input wire logic STRAP_DONE
);
    import rmsl_pkg::*;
    logic wr_ok;
    logic ok_d1;
    logic ok_d2;
    logic [2:0] wd_q;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    // expected flash visibility per strapped code
    function automatic logic fv(input logic [2:0] m, input logic f);
        case (m)
            3'h2: return 1'h0;
            3'h1, 3'h3: return !f;
            3'h5, 3'h7: return f;
            default: return 1'h1;
        endcase
    endfunction
    // expected {expanded, wide, emulation, peripheral}
    function automatic logic [3:0] bs(input logic [2:0] m);
        case (m)
            3'h1: return 4'hA;
            3'h2, 3'h7: return 4'hC;
            3'h3: return 4'hE;
            3'h5: return 4'h8;
            3'h6: return 4'h1;
            default: return 4'h0;
        endcase
    endfunction
    // accepted mode write and its delayed copies
    assign wr_ok = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR && PADDR == OFS_MODE_CTRL;
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ok_d1 <= 1'h0;
            ok_d2 <= 1'h0;
            wd_q <= 3'h0;
        end else begin
            ok_d1 <= wr_ok;
            ok_d2 <= ok_d1;
            if (wr_ok) begin
                wd_q <= PWDATA[2:0];
            end
        end
    end
    sequence s_access;
        PSEL && PENABLE && !PREADY;
    endsequence
    sequence s_wr_ok;
        wr_ok;
    endsequence
    AST_CAPTURE_MODE: assert property ($rose(STRAP_DONE) |->
        MODE_CODE == {MODE_SEL_BIT2, MODE_SEL_BIT1, MODE_SEL_BIT0}) else $error("mode not captured");
    AST_CAPTURE_FLASH: assert property ($rose(STRAP_DONE) |->
        FLASH_VISIBLE == fv(MODE_CODE, FLASH_STRAP_PIN)) else $error("flash bit wrong");
    AST_DEBUG_AT_CAPTURE: assert property ($rose(STRAP_DONE) |->
        DEBUG_ACTIVE == (MODE_CODE == 3'h0)) else $error("debug state wrong");
    AST_DEBUG_CMD: assert property (STRAP_DONE && DEBUG_ACTIVATE_CMD |-> ##2 DEBUG_ACTIVE)
        else $error("debug not activated");
    AST_DEBUG_IDLE: assert property (STRAP_DONE && !DEBUG_ACTIVE && !DEBUG_ACTIVATE_CMD
        && !$past(DEBUG_ACTIVATE_CMD) |=> !DEBUG_ACTIVE) else $error("debug woke alone");
    AST_BUS_SHAPE: assert property (STRAP_DONE |->
        {EXPANDED_BUS, WIDE_BUS, EMULATION_MODE, PERIPHERAL_MODE} == bs(MODE_CODE)) else $error("bus shape");
    AST_ONE_WAIT: assert property (s_access |=> PREADY ##1 !PREADY) else $error("wait state");
    AST_UNMAPPED: assert property (s_access and PADDR > OFS_CFG_STATUS |=>
        PSLVERR && PRDATA == 32'h0) else $error("unmapped not refused");
    AST_NO_PERIPH_WR: assert property (s_access and PWRITE && PADDR == OFS_MODE_CTRL
        && PWDATA[2:0] == 3'h6 |=> PSLVERR) else $error("code 110 accepted");
    AST_MODE_WRITE: assert property (s_wr_ok |-> ##2 MODE_CODE == wd_q)
        else $error("mode write lost");
    AST_MODE_HOLD: assert property (STRAP_DONE && $past(STRAP_DONE) && $changed(MODE_CODE)
        |-> ok_d2) else $error("mode changed alone");
    AST_FLASH_HOLD: assert property (STRAP_DONE && $past(STRAP_DONE) |-> $stable(FLASH_VISIBLE))
        else $error("flash bit moved");
endmodule
`default_nettype wire

/* rmsl_strap_latch.sv */
// mode strap latch: captures mode and flash strap pins after reset,
// holds the chip mode and flash visibility, exposes them over apb
// assumes strap pins are stable across reset release, apb on CLK_SYS
//
// What this block does
// R01 - eight modes from a three-bit code, each with own map and bus shape
// R02 - mode strap pins captured into the mode bits as reset rises
// R03 - mode bits readable; software may change them only in restricted ways
// R04 - flash strap pin captured into the flash visibility bit at reset rise
// R05 - flash visibility one maps the internal flash, zero removes it
// R06 - code 000 special single chip, debug active at once, flash visible
// R07 - other modes allow debug but it waits for a serial command
// R08 - code 001 emulation narrow, flash visible is inverse of strap
// R09 - code 010 special test wide, flash never visible
// R10 - code 011 emulation wide, flash visible is inverse of strap
// R11 - code 100 normal single chip, flash always visible
// R12 - code 101 normal narrow, flash visible follows strap
// R13 - board must never strap code 110, peripheral mode; flash would show
// R14 - code 111 normal wide, flash visible follows strap
// R15 - latched values hold between resets except permitted mode writes
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module rmsl_strap_latch (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [rmsl_pkg::APB_ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic MODE_SEL_BIT2,
    input wire logic MODE_SEL_BIT1,
    input wire logic MODE_SEL_BIT0,
    input wire logic FLASH_STRAP_PIN,
    input wire logic DEBUG_ACTIVATE_CMD,
    output logic [2:0] MODE_CODE,
    output logic FLASH_VISIBLE,
    output logic EXPANDED_BUS,
    output logic WIDE_BUS,
    output logic SPECIAL_MODE,
    output logic EMULATION_MODE,
    output logic PERIPHERAL_MODE,
    output logic DEBUG_ACTIVE,
    output logic STRAP_DONE
);
    import rmsl_pkg::*;

    typedef enum logic [1:0] {
        ST_FILL1,
        ST_FILL2,
        ST_CAPTURE,
        ST_RUN
    } rmsl_cap_t;

    rmsl_cap_t cap_state;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [2:0] mode;
    logic flash_visible_bit;
    logic [2:0] strap_mode;
    logic strap_flash;
    logic captured;
    logic debug_active;
    logic mode_wr_used;
    logic mode_wr_pend;
    logic [31:0] rd_word;
    logic addr_hit;
    logic mode_wr_allowed;
    logic access_start;
    logic access_end;
    logic [2:0] wr_mode;

    rmsl_dec_if run_dif ();
    rmsl_dec_if cap_dif ();

    // decoder on the running mode drives the bus shape
    assign run_dif.mode = mode;
    assign run_dif.flash_strap = sync2[3];
    rmsl_mode_decode u_run_dec (
        .dif(run_dif.dec)
    );

    // decoder on the synchronised pins gives the capture defaults
    assign cap_dif.mode = sync2[2:0];
    assign cap_dif.flash_strap = sync2[3];
    rmsl_mode_decode u_cap_dec (
        .dif(cap_dif.dec)
    );

    // two-stage synchroniser on the four strap pins
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
        end else begin
            sync1 <= {FLASH_STRAP_PIN, MODE_SEL_BIT2, MODE_SEL_BIT1, MODE_SEL_BIT0};
            sync2 <= sync1;
        end
    end

    // capture sequencer: wait for the synchroniser to fill, then latch once
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            cap_state <= ST_FILL1;
        end else begin
            case (cap_state)
                ST_FILL1: begin
                    cap_state <= ST_FILL2;
                end
                ST_FILL2: begin
                    cap_state <= ST_CAPTURE;
                end
                ST_CAPTURE: begin
                    cap_state <= ST_RUN;
                end
                ST_RUN: begin
                    cap_state <= ST_RUN; // held until the next reset [R15]
                end
                default: begin
                    cap_state <= ST_FILL1;
                end
            endcase
        end
    end

    // raw strap record, kept for software inspection
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            strap_mode <= RST_MODE;
            strap_flash <= 1'h0;
        end else if (cap_state == ST_CAPTURE) begin
            strap_mode <= sync2[2:0]; // [R02]
            strap_flash <= sync2[3]; // [R04]
        end
    end

    // capture done flag, gates software writes and debug commands
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            captured <= 1'h0;
        end else if (cap_state == ST_CAPTURE) begin
            captured <= 1'h1;
        end
    end

    // apb phase markers and the restricted mode write check
    assign access_start = PSEL && PENABLE && !PREADY;
    assign access_end = PSEL && PENABLE && PREADY;
    assign wr_mode = PWDATA[MODE_LSB +: MODE_W];
    // special modes may switch freely; a normal mode allows one switch,
    // and only to another normal mode; peripheral is never reachable
    assign mode_wr_allowed = captured && PSTRB[0]
        && (wr_mode != MODE_PERIPHERAL)
        && (!mode[MODE_NORMAL_BIT] || (!mode_wr_used && wr_mode[MODE_NORMAL_BIT])); // [R03]

    // running mode: strap at capture, then only accepted writes
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            mode <= RST_MODE;
        end else if (cap_state == ST_CAPTURE) begin
            mode <= sync2[2:0]; // [R02] [R01]
        end else if (mode_wr_pend && access_end) begin
            mode <= PWDATA[MODE_LSB +: MODE_W]; // [R03] [R15]
        end
    end

    // one-shot mark for the write allowed from a normal mode
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            mode_wr_used <= 1'h0;
        end else if (mode_wr_pend && access_end && mode[MODE_NORMAL_BIT]) begin
            mode_wr_used <= 1'h1; // [R03]
        end
    end

    // flash visibility: set once from mode and strap, then held
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            flash_visible_bit <= RST_FLASH_VIS;
        end else if (cap_state == ST_CAPTURE) begin
            flash_visible_bit <= cap_dif.flash_vis_dflt; // [R04] [R15]
        end
    end

    // background debug: live at once in special single chip, else on command
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            debug_active <= 1'h0;
        end else if (cap_state == ST_CAPTURE) begin
            debug_active <= (sync2[2:0] == MODE_SPECIAL_SINGLE); // [R06] [R07]
        end else if (captured && DEBUG_ACTIVATE_CMD) begin
            debug_active <= 1'h1; // [R07]
        end
    end

    // register read mux and address decode
    always_comb begin
        rd_word = 32'h0000_0000;
        addr_hit = 1'h1;
        case (PADDR)
            OFS_MODE_CTRL: begin
                rd_word[MODE_LSB +: MODE_W] = mode; // [R03]
            end
            OFS_MISC_CTRL: begin
                rd_word[MISC_FLASH_VIS_BIT] = flash_visible_bit;
            end
            OFS_CFG_STATUS: begin
                rd_word[ST_DONE_BIT] = captured;
                rd_word[ST_DBG_ACTIVE_BIT] = debug_active;
                rd_word[ST_EXPANDED_BIT] = run_dif.expanded;
                rd_word[ST_WIDE_BIT] = run_dif.wide;
                rd_word[ST_SPECIAL_BIT] = run_dif.special;
                rd_word[ST_EMULATION_BIT] = run_dif.emulation;
                rd_word[ST_WR_USED_BIT] = mode_wr_used;
                rd_word[ST_STRAP_MODE_LSB +: MODE_W] = strap_mode;
                rd_word[ST_STRAP_FLASH_BIT] = strap_flash;
            end
            default: begin
                addr_hit = 1'h0;
            end
        endcase
    end

    // apb answer: one wait state, pready for a single cycle
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            PREADY <= 1'h0;
        end else begin
            PREADY <= access_start;
        end
    end

    // read data, only alongside pready, zero otherwise
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            PRDATA <= RST_PRDATA;
        end else if (access_start && !PWRITE) begin
            PRDATA <= rd_word; // [R03]
        end else begin
            PRDATA <= RST_PRDATA;
        end
    end

    // error flag: unmapped address, or a refused mode write
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            PSLVERR <= 1'h0;
        end else if (access_start) begin
            PSLVERR <= !addr_hit || (PWRITE && (PADDR == OFS_MODE_CTRL) && !mode_wr_allowed); // [R03]
        end else begin
            PSLVERR <= 1'h0;
        end
    end

    // mode write decision, applied at the edge that completes the access
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            mode_wr_pend <= 1'h0;
        end else if (access_start) begin
            mode_wr_pend <= PWRITE && (PADDR == OFS_MODE_CTRL) && mode_wr_allowed;
        end else begin
            mode_wr_pend <= 1'h0;
        end
    end

    // registered mode and flash visibility for the chip
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            MODE_CODE <= RST_MODE;
            FLASH_VISIBLE <= RST_FLASH_VIS;
        end else begin
            MODE_CODE <= mode; // [R01]
            FLASH_VISIBLE <= flash_visible_bit; // [R05]
        end
    end

    // registered bus shape of the running mode
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            EXPANDED_BUS <= 1'h0;
            WIDE_BUS <= 1'h0;
            SPECIAL_MODE <= 1'h0;
            EMULATION_MODE <= 1'h0;
            PERIPHERAL_MODE <= 1'h0;
        end else begin
            EXPANDED_BUS <= run_dif.expanded; // [R01]
            WIDE_BUS <= run_dif.wide;
            SPECIAL_MODE <= run_dif.special;
            EMULATION_MODE <= run_dif.emulation;
            PERIPHERAL_MODE <= run_dif.peripheral;
        end
    end

    // registered debug state and capture status
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            DEBUG_ACTIVE <= 1'h0;
            STRAP_DONE <= 1'h0;
        end else begin
            DEBUG_ACTIVE <= debug_active; // [R07]
            STRAP_DONE <= captured;
        end
    end

endmodule
`default_nettype wire

/* tb_top.sv */
// bench for the mode strap latch: strap sweep, apb mode writes, debug
// assumes the board model drives the strap pins
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import rmsl_pkg::*;
    logic CLK_SYS, RST_N, PSEL, PENABLE, PWRITE, DEBUG_ACTIVATE_CMD, FLASH_STRAP_PIN;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA;
    logic [3:0] PSTRB;
    logic PREADY, PSLVERR, MODE_SEL_BIT2, MODE_SEL_BIT1, MODE_SEL_BIT0, FLASH_VISIBLE;
    logic EXPANDED_BUS, WIDE_BUS, SPECIAL_MODE, EMULATION_MODE, PERIPHERAL_MODE, DEBUG_ACTIVE, STRAP_DONE;
    logic [2:0] MODE_CODE, strap_req;
    logic flash_req;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    rmsl_strap_latch rmsl_strap_latch_inst (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .MODE_SEL_BIT2(MODE_SEL_BIT2), .MODE_SEL_BIT1(MODE_SEL_BIT1),
        .MODE_SEL_BIT0(MODE_SEL_BIT0), .FLASH_STRAP_PIN(FLASH_STRAP_PIN), .DEBUG_ACTIVATE_CMD(DEBUG_ACTIVATE_CMD),
        .MODE_CODE(MODE_CODE), .FLASH_VISIBLE(FLASH_VISIBLE), .EXPANDED_BUS(EXPANDED_BUS), .WIDE_BUS(WIDE_BUS),
        .SPECIAL_MODE(SPECIAL_MODE), .EMULATION_MODE(EMULATION_MODE), .PERIPHERAL_MODE(PERIPHERAL_MODE),
        .DEBUG_ACTIVE(DEBUG_ACTIVE), .STRAP_DONE(STRAP_DONE));
    rmsl_board_strap rmsl_board_strap_inst (.strap_req(strap_req), .flash_req(flash_req),
        .mode_bit2(MODE_SEL_BIT2), .mode_bit1(MODE_SEL_BIT1), .mode_bit0(MODE_SEL_BIT0), .flash_pin(FLASH_STRAP_PIN));
    // free-running system clock
    initial begin
        CLK_SYS = 1'h0;
        forever #2 CLK_SYS = ~CLK_SYS;
    end
    // hang guard
    always @(posedge CLK_SYS) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            end_sim();
        end
    end
    task automatic end_sim;
        if (errors == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready is sampled
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge CLK_SYS);
        PSEL <= 1'h1;
        PENABLE <= 1'h0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'h1;
        do begin
            @(posedge CLK_SYS);
        end while (PREADY !== 1'h1);
        r = PRDATA;
        e = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
    endtask
    task automatic do_reset(input logic [2:0] m, input logic f);
        @(posedge CLK_SYS);
        RST_N <= 1'h0;
        strap_req <= m;
        flash_req <= f;
        repeat (2) @(posedge CLK_SYS);
        RST_N <= 1'h1;
        repeat (6) @(posedge CLK_SYS);
    endtask
    function automatic logic xf(input logic [2:0] m, input logic f);
        case (m)
            3'h2: return 1'h0;
            3'h1, 3'h3: return !f;
            3'h5, 3'h7: return f;
            default: return 1'h1;
        endcase
    endfunction
    // every legal strap pattern with both flash levels
    task automatic t_straps;
        logic [31:0] r;
        logic e;
        for (int m = 0; m < 8; m++) for (int f = 0; f < 2; f++) if (m != 6) begin
            do_reset(3'(m), 1'(f));
            chk(32'(MODE_CODE), 32'(m));
            chk(32'(FLASH_VISIBLE), 32'(xf(3'(m), 1'(f))));
            chk(32'(DEBUG_ACTIVE), 32'(m == 0));
            chk(32'({STRAP_DONE, SPECIAL_MODE}), 32'({1'h1, 1'(m == 0 || m == 2)}));
            apb(1'h0, OFS_CFG_STATUS, 32'h0, r, e);
            chk(32'(r[12:8]), 32'({1'(f), 1'h0, 3'(m)}));
            apb(1'h0, OFS_MISC_CTRL, 32'h0, r, e);
            chk(r, 32'(xf(3'(m), 1'(f))));
        end
    endtask
    // restricted mode writes, unmapped access, debug activation
    task automatic t_write;
        logic [31:0] r;
        logic e;
        do_reset(3'h0, 1'h1);
        apb(1'h1, OFS_MODE_CTRL, 32'h6, r, e);
        chk(32'(e), 32'h1);
        apb(1'h1, OFS_MODE_CTRL, 32'h3, r, e);
        chk(32'(e), 32'h0);
        repeat (2) @(posedge CLK_SYS);
        chk(32'(MODE_CODE), 32'h3);
        chk(32'(FLASH_VISIBLE), 32'h1);
        do_reset(3'h4, 1'h0);
        chk(32'(DEBUG_ACTIVE), 32'h0);
        PSTRB <= 4'h0;
        apb(1'h1, OFS_MODE_CTRL, 32'h7, r, e);
        chk(32'(e), 32'h1);
        PSTRB <= 4'hF;
        apb(1'h1, OFS_MODE_CTRL, 32'h0, r, e);
        chk(32'(e), 32'h1);
        apb(1'h1, OFS_MODE_CTRL, 32'h7, r, e);
        chk(32'(e), 32'h0);
        apb(1'h1, OFS_MODE_CTRL, 32'h5, r, e);
        chk(32'(e), 32'h1);
        apb(1'h0, 12'h00C, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1);
        apb(1'h1, OFS_MISC_CTRL, 32'h0, r, e);
        chk(32'(e), 32'h0);
        apb(1'h0, OFS_MISC_CTRL, 32'h0, r, e);
        chk(r, 32'h1);
        apb(1'h0, OFS_MODE_CTRL, 32'h0, r, e);
        chk(r, 32'h7);
        @(posedge CLK_SYS);
        DEBUG_ACTIVATE_CMD <= 1'h1;
        @(posedge CLK_SYS);
        DEBUG_ACTIVATE_CMD <= 1'h0;
        repeat (2) @(posedge CLK_SYS);
        chk(32'(DEBUG_ACTIVE), 32'h1);
    endtask
    // main sequence
    initial begin
        RST_N = 1'h0;
        PSEL = 1'h0;
        PENABLE = 1'h0;
        PWRITE = 1'h0;
        PADDR = 12'h000;
        PWDATA = 32'h0;
        PSTRB = 4'hF;
        DEBUG_ACTIVATE_CMD = 1'h0;
        strap_req = 3'h0;
        flash_req = 1'h0;
        repeat (2) @(posedge CLK_SYS);
        RST_N <= 1'h1;
        t_straps();
        t_write();
        end_sim();
    end
endmodule
bind rmsl_strap_latch rmsl_sl_asserts rmsl_sl_asserts_inst (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .MODE_SEL_BIT2(MODE_SEL_BIT2), .MODE_SEL_BIT1(MODE_SEL_BIT1), .MODE_SEL_BIT0(MODE_SEL_BIT0),
    .FLASH_STRAP_PIN(FLASH_STRAP_PIN), .DEBUG_ACTIVATE_CMD(DEBUG_ACTIVATE_CMD), .MODE_CODE(MODE_CODE),
    .FLASH_VISIBLE(FLASH_VISIBLE), .EXPANDED_BUS(EXPANDED_BUS), .WIDE_BUS(WIDE_BUS),
    .EMULATION_MODE(EMULATION_MODE), .PERIPHERAL_MODE(PERIPHERAL_MODE), .DEBUG_ACTIVE(DEBUG_ACTIVE),
    .STRAP_DONE(STRAP_DONE));
`default_nettype wire
